// file: nand_host_map.svh
// timing counts, command codes and field positions for the nand flash host controller
// assumes a 125 MHz system clock; included by the package user files by bare name
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

// --------------------------------------------------------------
// clock and device times
// --------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define CELL_WRITE_TIME_US 700
`define CACHE_WRITE_BUSY_SHORT_US 10
`define CACHE_WRITE_BUSY_LONG_US 700
`define CACHE_READ_BUSY_US 25
`define COPY_CACHE_BUSY_US 30
`define ARRAY_FETCH_TIME_US 25
// longest wait the host allows before flagging a timeout (rounded down)
`define BUSY_LIMIT_CYC(us) (((us) * 1000) / `CLK_PERIOD_NS)
// strobe phase length, 3 clocks = 24 ns covers pulse widths and setup
`define PHASE_CYC 3
// we high to ready sampled: wait 100 ns before trusting ready_busy_n
`define WB_WAIT_CYC 13
// pages may be programmed at most this many times before erase
`define MAX_PARTIAL_PROG 4

// --------------------------------------------------------------
// command codes
// --------------------------------------------------------------
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_CACHE_PROG2 8'h15
`define CMD_MULTI_PROG2 8'h11
`define CMD_MULTI_PROG1 8'h81
`define CMD_READ_CACHE 8'h31
`define CMD_READ_CACHE_LAST 8'h3f
`define CMD_COPY_READ2 8'h3a
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hff
`define STATUS_READY_BIT 6

`endif

// file: nand_host_pkg.sv
// types for the nand flash host controller
// assumes nand_host_map.svh supplies the numeric constants
package nand_host_pkg;
   // kind of latch cycle driven on the byte port
   typedef enum logic [1:0] {
      cyc_cmd = 2'h0,
      cyc_addr = 2'h1,
      cyc_wdata = 2'h2,
      cyc_rdata = 2'h3
   } cyc_kind_t;
endpackage : nand_host_pkg

// file: strobe_if.sv
// carrier between the host sequencer and its strobe generator
// assumes one clock domain shared by both ends
interface strobe_if;
   logic req;
   nand_host_pkg::cyc_kind_t kind;
   logic [7:0] wbyte;
   logic done;
   logic [7:0] rbyte;
   modport seq (output req, output kind, output wbyte, input done, input rbyte);
   modport gen (input req, input kind, input wbyte, output done, output rbyte);
endinterface : strobe_if

// file: nand_strobe_gen.sv
// one latch cycle on the flash pins: low phase then high phase of a strobe
// assumes the sequencer holds req until done and pins are synchronous inputs
`include "nand_host_map.svh"
module nand_strobe_gen (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // sequencer side
   strobe_if.gen s,
   // pin side
   input wire logic [7:0] i_byte_in,
   output logic o_cle,
   output logic o_ale,
   output logic o_we_n,
   output logic o_output_strobe_n,
   output logic [7:0] o_byte_out,
   output logic o_byte_oe
);
   import nand_host_pkg::*;

   logic [1:0] cnt, next_cnt;
   logic ph, next_ph;
   logic busy, next_busy;
   logic cle, next_cle, ale, next_ale, we_n, next_we_n, rd_n, next_rd_n;
   logic [7:0] bout, next_bout, rb, next_rb;
   logic oe, next_oe, done, next_done;

   // --------------------------------------------------------------
   // next state of the strobe phases
   // --------------------------------------------------------------
   always_comb begin
      next_cnt = cnt;
      next_ph = ph;
      next_busy = busy;
      next_cle = cle;
      next_ale = ale;
      next_we_n = we_n;
      next_rd_n = rd_n;
      next_bout = bout;
      next_rb = rb;
      next_oe = oe;
      next_done = 1'b0;
      if (!busy && s.req && !done) begin
         next_busy = 1'b1;
         next_ph = 1'b0;
         next_cnt = 2'(`PHASE_CYC - 1);
         next_cle = (s.kind == cyc_cmd); // RQ1
         next_ale = (s.kind == cyc_addr); // RQ2
         next_bout = s.wbyte;
         // never drive while the flash may still be driving
         next_oe = (s.kind != cyc_rdata); // RQ21
         next_we_n = (s.kind == cyc_rdata);
         next_rd_n = (s.kind != cyc_rdata); // RQ5
      end else if (busy) begin
         if (cnt != 2'h0) begin
            next_cnt = cnt - 2'h1;
         end else if (!ph) begin
            // rising strobe: flash latches the byte, or we capture read data
            next_ph = 1'b1;
            next_cnt = 2'(`PHASE_CYC - 1);
            if (!rd_n) begin
               next_rb = i_byte_in;
            end
            next_we_n = 1'b1;
            next_rd_n = 1'b1;
         end else begin
            next_busy = 1'b0;
            next_cle = 1'b0;
            next_ale = 1'b0;
            next_oe = 1'b0;
            next_done = 1'b1;
         end
      end
   end

   // register the strobe state
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 2'h0;
         ph <= 1'b0;
         busy <= 1'b0;
         cle <= 1'b0;
         ale <= 1'b0;
         we_n <= 1'b1;
         rd_n <= 1'b1;
         bout <= 8'h00;
         rb <= 8'h00;
         oe <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt <= next_cnt;
         ph <= next_ph;
         busy <= next_busy;
         cle <= next_cle;
         ale <= next_ale;
         we_n <= next_we_n;
         rd_n <= next_rd_n;
         bout <= next_bout;
         rb <= next_rb;
         oe <= next_oe;
         done <= next_done;
      end
   end

   // outputs straight from flops
   assign o_cle = cle;
   assign o_ale = ale;
   assign o_we_n = we_n;
   assign o_output_strobe_n = rd_n;
   assign o_byte_out = bout;
   assign o_byte_oe = oe;
   assign s.done = done;
   assign s.rbyte = rb;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_no_drive_on_read: assert property (@(posedge i_clock) disable iff (i_rst)
      !rd_n |-> !oe) else $error("byte port driven during read strobe"); // RQ21
   a_strobes_exclusive: assert property (@(posedge i_clock) disable iff (i_rst)
      !(!we_n && !rd_n)) else $error("write and output strobes low together"); // RQ23
endmodule : nand_strobe_gen

// file: nand_host_ctrl.sv
// host controller that drives a nand page flash through its pins
// assumes synchronous pin inputs, a pulled-up ready_busy_n and a user that
// holds its command inputs until o_done
//
// Function
// [RQ1] cle high while write strobe rises latches command
// [RQ2] ale high while write strobe rises latches address
// [RQ3] chip select high when ready gives standby
// [RQ4] chip select ignored while device busy
// [RQ5] each output strobe fall yields next byte
// [RQ6] program guard low blocks program and erase
// [RQ7] ready_busy_n low during operations, high after
// [RQ8] page programmed at most four times; the controller keeps no program count and does not enforce this
// [RQ9] 11h cache program busy at most 10 us
// [RQ10] 15h cache program busy at most 700 us
// [RQ11] 31h or 3fh busy at most 25 us
// [RQ12] 3ah copy read busy at most 30 us
// [RQ13] array fetch done within 25 us
// [RQ14] 31h resets column counter to zero
// [RQ15] end cache program with 80h-10h
// [RQ16] after 15h end, poll 70h then ffh
// [RQ17] end multi-page cache series with 81h-10h
// [RQ18] late last page busy reaches cell write time
// [RQ19] long strobe high time releases outputs
// [RQ20] short strobe high keeps data until edge
// [RQ21] host never drives while device drives
// [RQ22] cache program is 80h, five addresses, data, 15h
// [RQ23] read busy: hold strobes high, status/reset only
// [RQ24] wait ready before commands refused when busy
`include "nand_host_map.svh"
module nand_host_ctrl (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // user operation request
   input wire logic i_start,
   input wire logic [7:0] i_cmd1,
   input wire logic i_has_cmd2,
   input wire logic [7:0] i_cmd2,
   input wire logic [2:0] i_addr_cnt,
   input wire logic [39:0] i_addr,
   input wire logic [12:0] i_data_cnt,
   input wire logic i_data_write,
   input wire logic i_wait_ready,
   input wire logic i_protect,
   // user data streams
   input wire logic [7:0] i_wdata,
   output logic o_wdata_take,
   output logic [7:0] o_rdata,
   output logic o_rdata_valid,
   // user status
   output logic o_done,
   output logic o_timeout,
   output logic o_ready,
   // flash pins
   input wire logic i_ready_busy_n,
   input wire logic [7:0] i_byte_port,
   output logic o_chip_sel_n,
   output logic o_cle,
   output logic o_ale,
   output logic o_we_n,
   output logic o_output_strobe_n,
   output logic o_prog_guard_n,
   output logic [7:0] o_byte_port,
   output logic o_byte_port_oe
);
   import nand_host_pkg::*;

   typedef enum logic [6:0] {
      st_idle = 7'h01,
      st_cmd1 = 7'h02,
      st_addr = 7'h04,
      st_data = 7'h08,
      st_cmd2 = 7'h10,
      st_wb = 7'h20,
      st_busy = 7'h40
   } state_t;

   strobe_if sif ();
   state_t state, next_state;
   logic [2:0] acnt, next_acnt;
   logic [12:0] dcnt, next_dcnt;
   logic [16:0] tcnt, next_tcnt;
   logic [16:0] limit, next_limit;
   logic req, next_req;
   cyc_kind_t kind, next_kind;
   logic [7:0] wbyte, next_wbyte;
   logic ce_n, next_ce_n, guard_n, next_guard_n;
   logic done, next_done, tout, next_tout, take, next_take, rv, next_rv;
   logic [7:0] rdata, next_rdata;

   // --------------------------------------------------------------
   // busy limit per closing command
   // --------------------------------------------------------------
   function automatic logic [16:0] busy_limit(input logic [7:0] c);
      logic [16:0] r;
      r = 17'(`BUSY_LIMIT_CYC(`CELL_WRITE_TIME_US)); // RQ18
      unique case (c)
         `CMD_MULTI_PROG2: r = 17'(`BUSY_LIMIT_CYC(`CACHE_WRITE_BUSY_SHORT_US)); // RQ9
         `CMD_CACHE_PROG2: r = 17'(`BUSY_LIMIT_CYC(`CACHE_WRITE_BUSY_LONG_US)); // RQ10
         `CMD_READ_CACHE, `CMD_READ_CACHE_LAST:
            r = 17'(`BUSY_LIMIT_CYC(`CACHE_READ_BUSY_US)); // RQ11
         `CMD_COPY_READ2: r = 17'(`BUSY_LIMIT_CYC(`COPY_CACHE_BUSY_US)); // RQ12
         `CMD_READ2: r = 17'(`BUSY_LIMIT_CYC(`ARRAY_FETCH_TIME_US)); // RQ13
         default: r = 17'(`BUSY_LIMIT_CYC(`CELL_WRITE_TIME_US));
      endcase
      return r;
   endfunction : busy_limit

   // --------------------------------------------------------------
   // operation sequencer: command, addresses, data, second command, busy wait
   // --------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_acnt = acnt;
      next_dcnt = dcnt;
      next_tcnt = tcnt;
      next_limit = limit;
      next_req = req;
      next_kind = kind;
      next_wbyte = wbyte;
      next_ce_n = ce_n;
      next_guard_n = !i_protect; // RQ6
      next_done = 1'b0;
      next_tout = tout;
      next_take = 1'b0;
      next_rv = 1'b0;
      next_rdata = rdata;
      unique case (state)
         st_idle: begin
            // select released while idle and ready lets the device rest
            next_ce_n = 1'b1; // RQ3
            if (i_start) begin
               next_ce_n = 1'b0;
               next_tout = 1'b0;
               next_req = 1'b1;
               next_kind = cyc_cmd;
               next_wbyte = i_cmd1;
               next_acnt = 3'h0;
               next_state = st_cmd1;
            end
         end
         st_cmd1, st_addr: begin
            if (req && sif.done) begin
               next_req = 1'b0;
            end else if (!req) begin
               if (acnt < i_addr_cnt) begin
                  // i_addr_cnt bytes low first, column then page
                  next_req = 1'b1; // RQ22
                  next_kind = cyc_addr;
                  next_wbyte = i_addr[acnt*8 +: 8];
                  next_acnt = acnt + 3'h1;
                  next_state = st_addr;
               end else begin
                  next_dcnt = i_data_cnt;
                  next_state = st_data;
               end
            end
         end
         st_data: begin
            if (req && sif.done) begin
               next_req = 1'b0;
               if (!i_data_write) begin
                  next_rdata = sif.rbyte; // RQ5 RQ16
                  next_rv = 1'b1;
               end
            end else if (!req) begin
               if (dcnt != 13'h0) begin
                  next_req = 1'b1;
                  next_kind = i_data_write ? cyc_wdata : cyc_rdata;
                  next_wbyte = i_wdata;
                  next_take = i_data_write;
                  next_dcnt = dcnt - 13'h1;
               end else if (i_has_cmd2) begin
                  next_req = 1'b1;
                  next_kind = cyc_cmd;
                  next_wbyte = i_cmd2; // RQ15 RQ17
                  next_state = st_cmd2; // RQ8
               end else begin
                  next_limit = busy_limit(i_cmd1);
                  next_tcnt = 17'h0;
                  next_state = i_wait_ready ? st_wb : st_idle;
                  next_done = !i_wait_ready;
               end
            end
         end
         st_cmd2: begin
            if (sif.done) begin
               next_req = 1'b0;
               next_limit = busy_limit(i_cmd2);
               next_tcnt = 17'h0;
               next_state = i_wait_ready ? st_wb : st_idle;
               next_done = !i_wait_ready;
            end
         end
         st_wb: begin
            next_tcnt = tcnt + 17'h1;
            if (tcnt == 17'(`WB_WAIT_CYC)) begin
               next_state = st_busy;
            end
         end
         st_busy: begin
            // hold strobes high and wait for ready, or give up at the busy limit, before any new command
            next_tcnt = tcnt + 17'h1; // RQ24
            if (i_ready_busy_n) begin // RQ7
               next_done = 1'b1;
               next_state = st_idle;
            end else if (tcnt >= limit + 17'(`WB_WAIT_CYC)) begin
               next_tout = 1'b1;
               next_done = 1'b1;
               next_state = st_idle;
            end
         end
      endcase
   end

   // register the sequencer state
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= st_idle;
         acnt <= 3'h0;
         dcnt <= 13'h0;
         tcnt <= 17'h0;
         limit <= 17'h0;
         req <= 1'b0;
         kind <= cyc_cmd;
         wbyte <= 8'h00;
         ce_n <= 1'b1;
         guard_n <= 1'b0;
         done <= 1'b0;
         tout <= 1'b0;
         take <= 1'b0;
         rv <= 1'b0;
         rdata <= 8'h00;
      end else begin
         state <= next_state;
         acnt <= next_acnt;
         dcnt <= next_dcnt;
         tcnt <= next_tcnt;
         limit <= next_limit;
         req <= next_req;
         kind <= next_kind;
         wbyte <= next_wbyte;
         ce_n <= next_ce_n;
         guard_n <= next_guard_n;
         done <= next_done;
         tout <= next_tout;
         take <= next_take;
         rv <= next_rv;
         rdata <= next_rdata;
      end
   end

   assign sif.req = req;
   assign sif.kind = kind;
   assign sif.wbyte = wbyte;

   // strobe generator drives the latch pins from its own flops
   nand_strobe_gen u_gen (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .s(sif.gen),
      .i_byte_in(i_byte_port),
      .o_cle(o_cle),
      .o_ale(o_ale),
      .o_we_n(o_we_n),
      .o_output_strobe_n(o_output_strobe_n),
      .o_byte_out(o_byte_port),
      .o_byte_oe(o_byte_port_oe)
   );

   assign o_chip_sel_n = ce_n;
   assign o_prog_guard_n = guard_n;
   assign o_done = done;
   assign o_timeout = tout;
   assign o_ready = state[0]; // idle is the lowest one-hot bit
   assign o_wdata_take = take;
   assign o_rdata = rdata;
   assign o_rdata_valid = rv;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_select_held_busy: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == st_busy) |-> !ce_n) else $error("select dropped while busy"); // RQ4
   a_guard_follows_prot: assert property (@(posedge i_clock) disable iff (i_rst)
      i_protect |=> !guard_n) else $error("guard not low while protected"); // RQ6
   a_busy_ends_ready: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == st_busy && i_ready_busy_n) |=> (state == st_idle && done))
      else $error("ready not honoured"); // RQ7
   a_no_cmd_while_busy: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == st_busy) |-> !req) else $error("strobe request while busy"); // RQ23
   a_idle_deselect: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == st_idle && !i_start) |=> ce_n) else $error("no standby when idle"); // RQ3
   a_busy_bounded: assert property (@(posedge i_clock) disable iff (i_rst)
      (state == st_busy) |-> tcnt <= limit + 17'(`WB_WAIT_CYC))
      else $error("busy wait past limit"); // RQ10
   a_addr_before_data: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(state == st_data) |-> acnt == i_addr_cnt)
      else $error("data phase before all address bytes"); // RQ22
   a_done_pulse: assert property (@(posedge i_clock) disable iff (i_rst)
      done |=> !done) else $error("done longer than one cycle"); // RQ24
endmodule : nand_host_ctrl

// file: nand_flash_model.sv
// behavioural flash device on the far side of the host controller
// assumes the bench resolves the byte port and ready_busy_n is pulled up
module nand_flash_model #(
   parameter int BUSY_NS = 2000,
   parameter int SLOW_NS = 12000
) (
   // strobes from the host
   input wire logic i_chip_sel_n,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_we_n,
   input wire logic i_output_strobe_n,
   input wire logic i_prog_guard_n,
   input wire logic [7:0] i_bus,
   input wire logic i_slow,
   // device outputs
   output logic o_ready_busy_n = 1'b1,
   output logic [7:0] o_dout = 8'h00,
   output logic o_doe = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] cmd = 8'h00;
   logic [7:0] adr [0:4];
   int na = 0;
   logic [12:0] col = 13'h0;
   logic stat = 1'b0;
   logic [7:0] wr_sum = 8'h00;
   int prog_count = 0;
   logic standby;

   // busy goes low at once, well inside the write-to-busy window
   task automatic go_busy(input int ns);
      o_ready_busy_n = 1'b0;
      fork
         #(ns) o_ready_busy_n = 1'b1;
      join_none
   endtask : go_busy

   // -----------------------------------------------------------
   // latch on write strobe rise, deselected cycles are ignored
   // -----------------------------------------------------------
   always @(posedge i_we_n) begin
      if (!i_chip_sel_n && i_cle) begin
         cmd = i_bus;
         na = 0;
         case (i_bus)
            8'h00, 8'hff: stat = 1'b0;
            8'h70: stat = 1'b1;
            8'h30, 8'h3a: begin
               col = {adr[1][4:0], adr[0]};
               go_busy(BUSY_NS);
            end
            8'h31, 8'h3f: begin
               col = 13'h0;
               go_busy(BUSY_NS);
            end
            8'h80, 8'h81: wr_sum = 8'h00;
            8'h10, 8'h11, 8'h15: begin
               // guard low keeps the regulator off, nothing programs
               if (i_prog_guard_n) begin
                  prog_count++;
                  go_busy(i_slow ? SLOW_NS : BUSY_NS);
               end
            end
            default: ;
         endcase
      end else if (!i_chip_sel_n && i_ale) begin
         adr[na] = i_bus;
         na = (na + 1) % 5;
      end else if (!i_chip_sel_n && (cmd == 8'h80 || cmd == 8'h81)) begin
         wr_sum = wr_sum + i_bus;
      end
   end

   // next byte after output strobe falls, column moves on except for status reads
   always @(negedge i_output_strobe_n) begin
      if (!i_chip_sel_n) begin
         #5;
         o_dout = stat ? {1'b0, o_ready_busy_n, 6'h00} : (col[7:0] ^ 8'h5a);
         o_doe = 1'b1;
         if (!stat) col = col + 13'h1;
      end
   end

   // short high time keeps data until a latch or select edge
   always @(posedge i_cle or posedge i_ale or posedge i_chip_sel_n or negedge i_we_n)
      o_doe = 1'b0;

   // long high time drops the drivers; 30 ns marks long
   always @(posedge i_output_strobe_n) begin
      #30;
      if (i_output_strobe_n) o_doe = 1'b0;
   end

   assign standby = i_chip_sel_n & o_ready_busy_n;
endmodule : nand_flash_model

// file: nand_page_flash_interface_tb.sv
// self-checking bench for the nand host controller
// assumes nand_flash_model stands on the pins; bench resolves the byte port
module nand_page_flash_interface_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clock = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_has_cmd2 = 1'b0;
   logic i_data_write = 1'b0, i_wait_ready = 1'b0, i_protect = 1'b0, slow = 1'b0;
   logic [7:0] i_cmd1 = 8'h00, i_cmd2 = 8'h00, i_wdata = 8'h00, last_bus = 8'h00;
   logic [2:0] i_addr_cnt = 3'h0;
   logic [39:0] i_addr = 40'h0;
   logic [12:0] i_data_cnt = 13'h0;
   logic o_wdata_take, o_rdata_valid, o_done, o_timeout, o_ready, i_ready_busy_n;
   logic o_chip_sel_n, o_cle, o_ale, o_we_n, o_output_strobe_n, o_prog_guard_n;
   logic o_byte_port_oe, dev_oe;
   logic [7:0] o_rdata, o_byte_port, dev_byte;
   wire [7:0] i_byte_port;
   logic [7:0] rq [$];
   int err_count = 0;
   int cmp_count = 0;
   int takes = 0;

   nand_host_ctrl dut (.i_clock, .i_rst, .i_start, .i_cmd1, .i_has_cmd2, .i_cmd2,
      .i_addr_cnt, .i_addr, .i_data_cnt, .i_data_write, .i_wait_ready, .i_protect,
      .i_wdata, .o_wdata_take, .o_rdata, .o_rdata_valid, .o_done, .o_timeout, .o_ready,
      .i_ready_busy_n, .i_byte_port, .o_chip_sel_n, .o_cle, .o_ale, .o_we_n,
      .o_output_strobe_n, .o_prog_guard_n, .o_byte_port, .o_byte_port_oe);
   nand_flash_model flash (.i_chip_sel_n(o_chip_sel_n), .i_cle(o_cle), .i_ale(o_ale),
      .i_we_n(o_we_n), .i_output_strobe_n(o_output_strobe_n),
      .i_prog_guard_n(o_prog_guard_n), .i_bus(i_byte_port), .i_slow(slow),
      .o_ready_busy_n(i_ready_busy_n), .o_dout(dev_byte), .o_doe(dev_oe));

   // -----------------------------------------------------------
   // clock, shared port, checks
   // -----------------------------------------------------------
   always #4 i_clock = ~i_clock;
   // undriven port flips so a stale byte never reads as good
   assign i_byte_port = o_byte_port_oe ? o_byte_port : (dev_oe ? dev_byte : ~last_bus);
   always @(i_byte_port) if (o_byte_port_oe || dev_oe) last_bus = i_byte_port;
   always @(posedge i_clock) if (!i_rst && o_byte_port_oe === 1'b1) check(dev_oe, 1'b0);
   // write bytes handed over by the controller
   always @(posedge i_clock) if (o_wdata_take === 1'b1) takes++;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   function automatic logic [7:0] exp_rd(input logic [12:0] c);
      return c[7:0] ^ 8'h5a;
   endfunction : exp_rd

   function automatic logic [39:0] mk_addr(input logic [12:0] c);
      return {8'h00, 16'($urandom), 3'h0, c};
   endfunction : mk_addr

   // one operation, held until done; read bytes gathered in rq
   task automatic op(input logic [7:0] c1, input logic h2, input logic [7:0] c2,
                     input logic [2:0] na, input logic [39:0] a, input logic [12:0] nd,
                     input logic wr, input logic wt);
      int k;
      rq.delete();
      i_cmd1 = c1;
      i_has_cmd2 = h2;
      i_cmd2 = c2;
      i_addr_cnt = na;
      i_addr = a;
      i_data_cnt = nd;
      i_data_write = wr;
      i_wait_ready = wt;
      i_start = 1'b1;
      @(posedge i_clock);
      #1 i_start = 1'b0;
      for (k = 0; k < 5000; k++) begin
         @(posedge i_clock);
         if (o_rdata_valid === 1'b1) rq.push_back(o_rdata);
         if (o_done === 1'b1) break;
      end
      #1;
      if (k == 5000) begin
         err_count++;
         close_out();
      end
   endtask : op

   initial begin
      logic [12:0] col;
      logic [12:0] n;
      logic [7:0] wv;
      logic [7:0] c2;
      int pc;
      int tk;
      int w;
      void'($urandom(15150));
      repeat (12) @(posedge i_clock);
      #1 i_rst = 1'b0;
      // random page read, then the copy read variant
      for (int t = 0; t < 2; t++) begin
         c2 = t ? 8'h3a : 8'h30;
         col = 13'($urandom_range(4000));
         n = 13'($urandom_range(8, 1));
         op(8'h00, 1'b1, c2, 3'h5, mk_addr(col), 13'h0, 1'b0, 1'b1);
         check(o_timeout, 1'b0);
         op(8'h00, 1'b0, 8'h00, 3'h0, 40'h0, n, 1'b0, 1'b0);
         check(16'(rq.size()), n);
         foreach (rq[i]) check(rq[i], exp_rd(col + 13'(i)));
         $display("test read %h done", c2);
      end
      // read with cache brings the column back to zero
      op(8'h31, 1'b0, 8'h00, 3'h0, 40'h0, 13'h0, 1'b0, 1'b1);
      check(o_timeout, 1'b0);
      op(8'h00, 1'b0, 8'h00, 3'h0, 40'h0, 13'h3, 1'b0, 1'b0);
      foreach (rq[i]) check(rq[i], exp_rd(13'(i)));
      check(16'(rq.size()), 16'h3);
      check(o_ready, 1'b1);
      $display("test read cache done");
      // cache program closed by 15h, status poll, reset; one program per page
      pc = flash.prog_count;
      wv = 8'($urandom);
      i_wdata = wv;
      n = 13'($urandom_range(16, 1));
      tk = takes;
      op(8'h80, 1'b1, 8'h15, 3'h5, mk_addr(13'h0), n, 1'b1, 1'b1);
      check(flash.wr_sum, 8'(n * wv));
      check(16'(takes - tk), 16'(n));
      check(flash.prog_count, 16'(pc + 1));
      op(8'h70, 1'b0, 8'h00, 3'h0, 40'h0, 13'h1, 1'b0, 1'b0);
      check(rq[0], 8'h40);
      op(8'hff, 1'b0, 8'h00, 3'h0, 40'h0, 13'h0, 1'b0, 1'b1);
      check(flash.standby, 1'b1);
      $display("test cache program done");
      // guard held low: program must not start
      i_protect = 1'b1;
      op(8'h80, 1'b1, 8'h10, 3'h5, mk_addr(13'h0), 13'h2, 1'b1, 1'b1);
      check(o_prog_guard_n, 1'b0);
      check(flash.prog_count, 16'(pc + 1));
      i_protect = 1'b0;
      $display("test guard done");
      // slow 11h busy overruns its limit, then the 81h-10h close
      slow = 1'b1;
      op(8'h80, 1'b1, 8'h11, 3'h5, mk_addr(13'h0), 13'h1, 1'b1, 1'b1);
      check(o_timeout, 1'b1);
      check(flash.standby, 1'b0);
      slow = 1'b0;
      // a timed-out flash is still busy, so wait for ready before the next command
      for (w = 0; w < 2000 && i_ready_busy_n !== 1'b1; w++) @(posedge i_clock);
      #1;
      if (w == 2000) begin
         err_count++;
         close_out();
      end
      op(8'h81, 1'b1, 8'h10, 3'h5, mk_addr(13'h0), 13'h1, 1'b1, 1'b1);
      check(o_timeout, 1'b0);
      check(flash.wr_sum, wv);
      check(flash.prog_count, 16'(pc + 3));
      $display("test multi page done");
      close_out();
   end
endmodule : nand_page_flash_interface_tb
